// [dcad_adder.sv]
// Adder unit: 16-bit sum with carry, nibble carry and signed overflow
`timescale 1ns/1ps
module dcad_adder
  import dcad_pkg::*;
(
  dcad_if.unit a
);
  logic [DATA_W:0]  full;
  logic [NIB_W:0]   low;
  // ==========================================================================
  // Sum
  always_comb
  begin
    full    = {1'b0, a.opa} + {1'b0, a.opb} + {{DATA_W{1'b0}}, a.cin};
    low     = {1'b0, a.opa[NIB_W-1:0]} + {1'b0, a.opb[NIB_W-1:0]} + {{NIB_W{1'b0}}, a.cin};
    a.sum   = full[DATA_W-1:0];
    a.cout  = full[DATA_W];
    a.dcout = low[NIB_W];
    // Overflow when like-signed operands give a differently signed sum
    a.ovf   = (a.opa[DATA_W-1] == a.opb[DATA_W-1]) && (full[DATA_W-1] != a.opa[DATA_W-1]);
  end
endmodule : dcad_adder

// [dcad_if.sv]
// Interface: operands and result between the datapath top and its adder unit
`timescale 1ns/1ps
interface dcad_if;
  import dcad_pkg::*;
  logic [DATA_W-1:0] opa;
  logic [DATA_W-1:0] opb;
  logic              cin;
  logic [DATA_W-1:0] sum;
  logic              cout;
  logic              dcout;
  logic              ovf;
  modport top (output opa, output opb, output cin, input sum, input cout, input dcout, input ovf);
  modport unit (input opa, input opb, input cin, output sum, output cout, output dcout, output ovf);
endinterface : dcad_if

// [dcad_partner.sv]
// Partner model: working register file fed by the datapath write-back
`timescale 1ns/1ps
module dcad_partner
  import dcad_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire logic              wr_en_i,
  input  wire logic              wr_work_i,
  input  wire logic [DATA_W-1:0] result_i,
  output logic      [DATA_W-1:0] work_o,
  output logic      [DATA_W-1:0] dest_o
);
  // ==========================================================================
  // Write-back; only the last destination is kept to stay small
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      work_o <= 16'h0000;
      dest_o <= 16'h0000;
    end
    else if (wr_en_i && wr_work_i)
      work_o <= result_i;
    else if (wr_en_i)
      dest_o <= result_i;
  end
endmodule : dcad_partner

// [dcad_pkg.sv]
// Package: opcodes, flag positions and widths for the arithmetic/branch datapath
package dcad_pkg;
  // ==========================================================================
  // Widths
  localparam int DATA_W  = 16;
  localparam int ACC_W   = 40;
  localparam int SEL_W   = 4;
  // ==========================================================================
  // Status flag positions
  localparam int FLG_C   = 0;
  localparam int FLG_Z   = 1;
  localparam int FLG_WRAP   = 2;
  localparam int FLG_N      = 3;
  localparam int FLG_NIB    = 4;
  localparam int FLG_AWRAP  = 5;
  localparam int FLG_BWRAP  = 6;
  localparam int FLG_ACLAMP = 7;
  localparam int FLG_BCLAMP = 8;
  localparam int FLG_W   = 9;
  localparam logic [FLG_W-1:0] FLAGS_RST = 9'h000;
  // ==========================================================================
  // Literal widths and nibble boundary
  localparam int LIT10_W = 10;
  localparam int LIT5_W  = 5;
  localparam int SLIT4_W = 4;
  localparam int NIB_W   = 4;
  localparam int SHAMT_W = 4;
  // ==========================================================================
  // Operations
  typedef enum logic [4:0] {
    OP_NOP, OP_SUM, OP_SUM_CARRY, OP_AND, OP_SHR1, OP_SHRN,
    OP_ACC_ADD, OP_BIT_ZERO, OP_BIT_RAISE, OP_BIT_INV,
    OP_STORE_C, OP_STORE_Z, OP_JUMP
  } dcad_op_t;
  // Jump conditions
  typedef enum logic [3:0] {
    CND_LTU, CND_AWRAP, CND_BWRAP, CND_ACLAMP, CND_BCLAMP, CND_NN, CND_NOV, CND_ALWAYS
  } dcad_cond_t;
endpackage : dcad_pkg

// [dcad_top.sv]
// Datapath top: arithmetic, shift, bit and conditional jump execution
`timescale 1ns/1ps
module dcad_top
  import dcad_pkg::*;
(
  input  wire logic              CLOCK_I,
  input  wire logic              RESET_I,
  input  wire logic              VALID_I,
  input  wire dcad_op_t          OP_I,
  input  wire dcad_cond_t        COND_I,
  input  wire logic [DATA_W-1:0] OPA_I,
  input  wire logic [DATA_W-1:0] OPB_I,
  input  wire logic              TO_WORK_I,
  input  wire logic              ACC_SEL_I,
  input  wire logic [SLIT4_W-1:0] SLIT4_I,
  output logic      [DATA_W-1:0] RESULT_O,
  output logic                   WR_EN_O,
  output logic                   WR_WORK_O,
  output logic                   JUMP_O,
  output logic      [FLG_W-1:0]  FLAGS_O,
  output logic      [ACC_W-1:0]  ACC_A_O,
  output logic      [ACC_W-1:0]  ACC_B_O
);
  dcad_if add_bus ();
  dcad_adder u_adder (.a(add_bus.unit));

  localparam logic [ACC_W-1:0] ACC_MAX = {1'b0, {(ACC_W-1){1'b1}}};
  localparam logic [ACC_W-1:0] ACC_MIN = {1'b1, {(ACC_W-1){1'b0}}};
  localparam int WIDE_W = ACC_W + 1;

  logic [DATA_W-1:0] result, next_result;
  logic              wr_en, next_wr_en, wr_work, next_wr_work, jump, next_jump;
  logic [FLG_W-1:0]  flags, next_flags;
  logic [ACC_W-1:0]  acc_a, acc_b, next_acc_a, next_acc_b;
  logic [ACC_W-1:0]  acc_cur, addend;
  logic [WIDE_W-1:0] acc_sum;
  logic [DATA_W-1:0] shifted, bmask;
  logic [SHAMT_W-1:0] bpos;
  logic [LIT5_W-1:0]  amt;
  logic              wrap;
  logic              cond_ok;

  // ==========================================================================
  // Adder operands
  always_comb
  begin
    add_bus.opa = OPA_I;
    add_bus.opb = OPB_I;
    add_bus.cin = (OP_I == OP_SUM_CARRY) ? flags[FLG_C] : 1'b0;
  end

  // ==========================================================================
  // Jump condition
  always_comb
  begin
    unique case (COND_I)
      CND_LTU:    cond_ok = !flags[FLG_C];
      CND_AWRAP:  cond_ok = flags[FLG_AWRAP];
      CND_BWRAP:  cond_ok = flags[FLG_BWRAP];
      CND_ACLAMP: cond_ok = flags[FLG_ACLAMP];
      CND_BCLAMP: cond_ok = flags[FLG_BCLAMP];
      CND_NN:     cond_ok = !flags[FLG_N];
      CND_NOV:    cond_ok = !flags[FLG_WRAP];
      CND_ALWAYS: cond_ok = 1'b1;
      default:    cond_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // Accumulator path: shift by signed literal, positive means right
  always_comb
  begin
    acc_cur = ACC_SEL_I ? acc_b : acc_a;
    addend  = {{(ACC_W-DATA_W){OPA_I[DATA_W-1]}}, OPA_I};
    if (SLIT4_I[SLIT4_W-1])
      addend = addend << (SHAMT_W'(~SLIT4_I) + SHAMT_W'(1));
    else
      addend = $signed(addend) >>> SLIT4_I;
    acc_sum = {acc_cur[ACC_W-1], acc_cur} + {addend[ACC_W-1], addend};
    wrap    = acc_sum[ACC_W] != acc_sum[ACC_W-1];
  end

  // ==========================================================================
  // Execute
  always_comb
  begin
    next_result  = result;
    next_wr_en   = 1'b0;
    next_wr_work = 1'b0;
    next_jump    = 1'b0;
    next_flags   = flags;
    next_acc_a   = acc_a;
    next_acc_b   = acc_b;
    bpos         = OPB_I[SHAMT_W-1:0];
    bmask        = DATA_W'(1) << bpos;
    amt          = OPB_I[LIT5_W-1:0];
    shifted      = DATA_W'($signed(OPA_I) >>> amt);
    if (VALID_I)
    begin
      unique case (OP_I)
        OP_SUM, OP_SUM_CARRY:
        begin
          next_result          = add_bus.sum;
          next_wr_en           = 1'b1;
          next_wr_work         = TO_WORK_I;
          next_flags[FLG_C]    = add_bus.cout;
          next_flags[FLG_NIB]  = add_bus.dcout;
          next_flags[FLG_WRAP] = add_bus.ovf;
          next_flags[FLG_N]    = add_bus.sum[DATA_W-1];
          // Carry form keeps Z sticky so multiword sums test the whole value
          next_flags[FLG_Z]    = (OP_I == OP_SUM_CARRY)
                                 ? (flags[FLG_Z] && add_bus.sum == '0)
                                 : (add_bus.sum == '0);
        end
        OP_AND:
        begin
          next_result       = OPA_I & OPB_I;
          next_wr_en        = 1'b1;
          next_wr_work      = TO_WORK_I;
          next_flags[FLG_N] = next_result[DATA_W-1];
          next_flags[FLG_Z] = next_result == '0;
        end
        OP_SHR1:
        begin
          next_result        = {OPA_I[DATA_W-1], OPA_I[DATA_W-1:1]};
          next_wr_en         = 1'b1;
          next_wr_work         = TO_WORK_I;
          next_flags[FLG_C]    = OPA_I[0];
          next_flags[FLG_WRAP] = 1'b0;
          next_flags[FLG_N]  = OPA_I[DATA_W-1];
          next_flags[FLG_Z]  = next_result == '0;
        end
        OP_SHRN:
        begin
          next_result       = shifted;
          next_wr_en        = 1'b1;
          next_flags[FLG_N] = shifted[DATA_W-1];
          next_flags[FLG_Z] = shifted == '0;
        end
        OP_ACC_ADD:
        begin
          if (ACC_SEL_I)
          begin
            next_acc_b         = wrap ? (acc_sum[ACC_W] ? ACC_MIN : ACC_MAX)
                                      : acc_sum[ACC_W-1:0];
            next_flags[FLG_BWRAP]  = wrap;
            next_flags[FLG_BCLAMP] = flags[FLG_BCLAMP] | wrap;
          end
          else
          begin
            next_acc_a         = wrap ? (acc_sum[ACC_W] ? ACC_MIN : ACC_MAX)
                                      : acc_sum[ACC_W-1:0];
            next_flags[FLG_AWRAP]  = wrap;
            next_flags[FLG_ACLAMP] = flags[FLG_ACLAMP] | wrap;
          end
        end
        OP_BIT_ZERO, OP_BIT_RAISE, OP_BIT_INV:
        begin
          next_wr_en   = 1'b1;
          next_wr_work = TO_WORK_I;
          unique case (OP_I)
            OP_BIT_ZERO:  next_result = OPA_I & ~bmask;
            OP_BIT_RAISE: next_result = OPA_I | bmask;
            default:      next_result = OPA_I ^ bmask;
          endcase
        end
        OP_STORE_C, OP_STORE_Z:
        begin
          next_wr_en  = 1'b1;
          next_result = OPA_I & ~bmask;
          if ((OP_I == OP_STORE_C) ? flags[FLG_C] : flags[FLG_Z])
            next_result = OPA_I | bmask;
        end
        OP_JUMP:  next_jump = cond_ok;
        default:  next_result = result;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      result  <= '0;
      wr_en   <= 1'b0;
      wr_work <= 1'b0;
      jump    <= 1'b0;
      flags   <= FLAGS_RST;
      acc_a   <= '0;
      acc_b   <= '0;
    end
    else
    begin
      result  <= next_result;
      wr_en   <= next_wr_en;
      wr_work <= next_wr_work;
      jump    <= next_jump;
      flags   <= next_flags;
      acc_a   <= next_acc_a;
      acc_b   <= next_acc_b;
    end
  end

  assign RESULT_O  = result;
  assign WR_EN_O   = wr_en;
  assign WR_WORK_O = wr_work;
  assign JUMP_O    = jump;
  assign FLAGS_O   = flags;
  assign ACC_A_O   = acc_a;
  assign ACC_B_O   = acc_b;

  // ==========================================================================
  // Checks
  chk_jump_flags_kept: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_JUMP |=> flags == $past(flags))
    else $error("jump changed flags");
  chk_nn_jump: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_JUMP && COND_I == CND_NN |=> jump == !$past(flags[FLG_N]))
    else $error("not-negative jump wrong");
  chk_ltu_jump: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_JUMP && COND_I == CND_LTU |=> jump == !$past(flags[FLG_C]))
    else $error("unsigned less-than jump wrong");
  chk_nov_jump: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_JUMP && COND_I == CND_NOV |=> jump == !$past(flags[FLG_WRAP]))
    else $error("not-overflow jump wrong");
  chk_awrap_jump: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_JUMP && COND_I == CND_AWRAP |=> jump == $past(flags[FLG_AWRAP]))
    else $error("acc A overflow jump wrong");
  chk_aclamp_jump: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_JUMP && COND_I == CND_ACLAMP |=> jump == $past(flags[FLG_ACLAMP]))
    else $error("acc A saturation jump wrong");
  chk_bclamp_jump: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_JUMP && COND_I == CND_BCLAMP |=> jump == $past(flags[FLG_BCLAMP]))
    else $error("acc B saturation jump wrong");
  chk_and_keeps_c: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_AND |=> flags[FLG_C] == $past(flags[FLG_C]) && wr_en)
    else $error("and altered carry");
  chk_shr1_sign: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_SHR1 |=> result[DATA_W-1] == result[DATA_W-2] && wr_en)
    else $error("sign not replicated");
  chk_shrn_keeps_cov: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_SHRN |=> flags[FLG_C] == $past(flags[FLG_C])
      && flags[FLG_WRAP] == $past(flags[FLG_WRAP]))
    else $error("multi shift altered carry or wrap");
  chk_store_c_bit: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_STORE_C |=> result[$past(bpos)] == $past(flags[FLG_C]))
    else $error("carry bit not stored");
  chk_acc_flags_only: assert property (@(posedge CLOCK_I) disable iff (RESET_I)
    VALID_I && OP_I == OP_ACC_ADD |=> flags[FLG_C] == $past(flags[FLG_C]) && !wr_en)
    else $error("acc add touched C or wrote");
  cov_sum_carry: cover property (@(posedge CLOCK_I) VALID_I && OP_I == OP_SUM_CARRY && flags[FLG_C]);
  cov_jump_taken: cover property (@(posedge CLOCK_I) jump);
  cov_acc_sat: cover property (@(posedge CLOCK_I) VALID_I && OP_I == OP_ACC_ADD && wrap);
endmodule : dcad_top

// [dcad_top_test.sv]
// Testbench: directed scenarios for the arithmetic/branch datapath
`timescale 1ns/1ps
module dcad_top_test;
  import dcad_pkg::*;
  localparam int SAT_ADDS = 65540;
  logic clk, rst, valid, to_work, acc_sel, wr_en, wr_work, jump;
  dcad_op_t op;
  dcad_cond_t cond;
  logic [DATA_W-1:0] opa, opb, result, pwork, pdest;
  logic [SLIT4_W-1:0] slit4;
  logic [FLG_W-1:0] flags;
  logic [ACC_W-1:0] acc_a, acc_b;
  int bad_count;
  int comparisons;

  dcad_top i_dcad_top (.CLOCK_I(clk), .RESET_I(rst), .VALID_I(valid), .OP_I(op),
    .COND_I(cond), .OPA_I(opa), .OPB_I(opb), .TO_WORK_I(to_work), .ACC_SEL_I(acc_sel),
    .SLIT4_I(slit4), .RESULT_O(result), .WR_EN_O(wr_en), .WR_WORK_O(wr_work),
    .JUMP_O(jump), .FLAGS_O(flags), .ACC_A_O(acc_a), .ACC_B_O(acc_b));
  dcad_partner i_dcad_partner (.clock_i(clk), .reset_i(rst), .wr_en_i(wr_en),
    .wr_work_i(wr_work), .result_i(result), .work_o(pwork), .dest_o(pdest));

  // ==========================================================================
  // Helpers
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task end_sim;
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task check(input string name, input logic [ACC_W-1:0] seen, input logic [ACC_W-1:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [FLG_W-1:0] fl(logic c, logic z, logic ov, logic n, logic dc);
    fl = 9'h000;
    fl[FLG_C] = c;
    fl[FLG_Z] = z;
    fl[FLG_WRAP] = ov;
    fl[FLG_N] = n;
    fl[FLG_NIB] = dc;
  endfunction : fl

  // Drive at the falling edge; outputs are settled one falling edge later
  task run(input dcad_op_t o, input dcad_cond_t c, input logic [15:0] a, input logic [15:0] b,
           input logic w);
    @(negedge clk);
    valid = 1'b1;
    op = o;
    cond = c;
    opa = a;
    opb = b;
    to_work = w;
    @(negedge clk);
    valid = 1'b0;
  endtask : run

  task res(input logic [15:0] r, input logic [FLG_W-1:0] f);
    check("result", result, r);
    check("flags", flags, f);
    check("wr_en", wr_en, 1'b1);
  endtask : res

  // ==========================================================================
  // Scenarios
  task t_reset;
    check("reset result", result, 16'h0000);
    check("reset flags", flags, FLAGS_RST);
    check("reset acc", acc_a | acc_b, 40'h0000000000);
  endtask : t_reset

  task t_sum;
    run(OP_SUM, CND_ALWAYS, 16'h7fff, 16'h0001, 1'b0);
    res(16'h8000, fl(0, 0, 1, 1, 1));
    run(OP_SUM, CND_ALWAYS, 16'hffff, 16'h0001, 1'b0);
    res(16'h0000, fl(1, 1, 0, 0, 1));
  endtask : t_sum

  // Carry chains in; zero only ever clears
  task t_sumc;
    run(OP_SUM_CARRY, CND_ALWAYS, 16'h0001, 16'h03ff, 1'b0);
    res(16'h0401, fl(0, 0, 0, 0, 1));
    run(OP_SUM_CARRY, CND_ALWAYS, 16'hffff, 16'h0001, 1'b0);
    res(16'h0000, fl(1, 0, 0, 0, 1));
    run(OP_SUM_CARRY, CND_ALWAYS, 16'h0010, 16'h001f, 1'b0);
    res(16'h0030, fl(0, 0, 0, 0, 1));
  endtask : t_sumc

  task t_jltu;
    run(OP_JUMP, CND_LTU, 16'h0000, 16'h0000, 1'b0);
    check("jump ltu", jump, 1'b1);
    check("jump flags", flags, fl(0, 0, 0, 0, 1));
    @(negedge clk);
    check("jump pulse", jump, 1'b0);
  endtask : t_jltu

  task t_shift;
    run(OP_SHR1, CND_ALWAYS, 16'h8003, 16'h0000, 1'b0);
    res(16'hc001, fl(1, 0, 0, 1, 1));
    run(OP_SHR1, CND_ALWAYS, 16'h0003, 16'h0000, 1'b1);
    res(16'h0001, fl(1, 0, 0, 0, 1));
    check("to work", wr_work, 1'b1);
    @(negedge clk);
    check("work reg", pwork, 16'h0001);
    run(OP_SHRN, CND_ALWAYS, 16'h8000, 16'h0004, 1'b0);
    res(16'hf800, fl(1, 0, 0, 1, 1));
    run(OP_SHRN, CND_ALWAYS, 16'h8000, 16'h0014, 1'b0);
    res(16'hffff, fl(1, 0, 0, 1, 1));
  endtask : t_shift

  task t_and;
    run(OP_AND, CND_ALWAYS, 16'hf0f0, 16'h0f0f, 1'b0);
    res(16'h0000, fl(1, 1, 0, 0, 1));
  endtask : t_and

  // Flags are C=1, Z=1 here and must not move
  task t_bits;
    run(OP_STORE_C, CND_ALWAYS, 16'h0000, 16'h0005, 1'b0);
    res(16'h0020, fl(1, 1, 0, 0, 1));
    check("store dest", wr_work, 1'b0);
    @(negedge clk);
    check("store dest reg", pdest, 16'h0020);
    run(OP_STORE_Z, CND_ALWAYS, 16'h0000, 16'h0003, 1'b0);
    res(16'h0008, fl(1, 1, 0, 0, 1));
    run(OP_BIT_ZERO, CND_ALWAYS, 16'hffff, 16'h000f, 1'b0);
    res(16'h7fff, fl(1, 1, 0, 0, 1));
    run(OP_BIT_RAISE, CND_ALWAYS, 16'h0000, 16'h0000, 1'b0);
    res(16'h0001, fl(1, 1, 0, 0, 1));
    run(OP_BIT_INV, CND_ALWAYS, 16'h0010, 16'h0004, 1'b0);
    res(16'h0000, fl(1, 1, 0, 0, 1));
  endtask : t_bits

  task t_jclear;
    run(OP_JUMP, CND_NN, 16'h0000, 16'h0000, 1'b0);
    check("jump nn", jump, 1'b1);
    run(OP_JUMP, CND_NOV, 16'h0000, 16'h0000, 1'b0);
    check("jump nov", jump, 1'b1);
    run(OP_SUM, CND_ALWAYS, 16'h7fff, 16'h0001, 1'b0);
    run(OP_JUMP, CND_NN, 16'h0000, 16'h0000, 1'b0);
    check("no jump nn", jump, 1'b0);
    run(OP_JUMP, CND_NOV, 16'h0000, 16'h0000, 1'b0);
    check("no jump nov", jump, 1'b0);
    run(OP_STORE_C, CND_ALWAYS, 16'hffff, 16'h0005, 1'b0);
    res(16'hffdf, fl(0, 0, 1, 1, 1));
    run(OP_STORE_Z, CND_ALWAYS, 16'hffff, 16'h0002, 1'b0);
    res(16'hfffb, fl(0, 0, 1, 1, 1));
  endtask : t_jclear

  // Small adds cannot wrap or clamp, so no accumulator jump may be taken
  task t_acc;
    acc_sel = 1'b0;
    run(OP_ACC_ADD, CND_ALWAYS, 16'h0001, 16'h0000, 1'b0);
    check("acc a set", acc_a, 40'h0000000001);
    check("acc b kept", acc_b, 40'h0000000000);
    slit4 = 4'hf;
    run(OP_ACC_ADD, CND_ALWAYS, 16'h0001, 16'h0000, 1'b0);
    check("acc a left", acc_a, 40'h0000000003);
    slit4 = 4'h1;
    run(OP_ACC_ADD, CND_ALWAYS, 16'h0004, 16'h0000, 1'b0);
    check("acc a right", acc_a, 40'h0000000005);
    slit4 = 4'h0;
    acc_sel = 1'b1;
    run(OP_ACC_ADD, CND_ALWAYS, 16'hffff, 16'h0000, 1'b0);
    check("acc b set", acc_b, 40'hffffffffff);
    check("acc flags", flags, fl(0, 0, 1, 1, 1));
    for (int i = 1; i <= 4; i++)
    begin
      run(OP_JUMP, dcad_cond_t'(i), 16'h0000, 16'h0000, 1'b0);
      check("acc jump", jump, 1'b0);
    end
  endtask : t_acc

  // Largest addend back to back until acc A clamps; the clamp flag must then stick
  task t_sat;
    acc_sel = 1'b0;
    slit4 = 4'h8;
    @(negedge clk);
    valid = 1'b1;
    op = OP_ACC_ADD;
    opa = 16'h7fff;
    repeat (SAT_ADDS) @(negedge clk);
    valid = 1'b0;
    check("acc a clamp", acc_a, 40'h7fffffffff);
    check("clamp flags", flags,
          fl(0, 0, 1, 1, 1) | (9'h001 << FLG_AWRAP) | (9'h001 << FLG_ACLAMP));
    run(OP_JUMP, CND_AWRAP, 16'h0000, 16'h0000, 1'b0);
    check("jump a wrap", jump, 1'b1);
    run(OP_JUMP, CND_ACLAMP, 16'h0000, 16'h0000, 1'b0);
    check("jump a clamp", jump, 1'b1);
    run(OP_ACC_ADD, CND_ALWAYS, 16'h0000, 16'h0000, 1'b0);
    check("acc a held", acc_a, 40'h7fffffffff);
    run(OP_JUMP, CND_AWRAP, 16'h0000, 16'h0000, 1'b0);
    check("no jump a wrap", jump, 1'b0);
    run(OP_JUMP, CND_ACLAMP, 16'h0000, 16'h0000, 1'b0);
    check("sticky clamp", jump, 1'b1);
    run(OP_JUMP, CND_BCLAMP, 16'h0000, 16'h0000, 1'b0);
    check("no jump b clamp", jump, 1'b0);
  endtask : t_sat

  // ==========================================================================
  // Main sequence and watchdog
  initial
  begin
    bad_count = 0;
    comparisons = 0;
    rst = 1'b1;
    {valid, to_work, acc_sel} = 3'h0;
    op = OP_NOP;
    cond = CND_LTU;
    opa = 16'h0000;
    opb = 16'h0000;
    slit4 = 4'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_sum();
    t_sumc();
    t_jltu();
    t_shift();
    t_and();
    t_bits();
    t_jclear();
    t_acc();
    t_sat();
    end_sim();
  end

  // About 66,000 cycles, nearly all in the clamp run; stop at 90,000
  initial
  begin
    #360000;
    bad_count++;
    end_sim();
  end
endmodule : dcad_top_test
